// *** hw/power_mode_regs.svh ***
// Constants for the power mode controller
`ifndef POWER_MODE_REGS_SVH
`define POWER_MODE_REGS_SVH

`define PMC_CFG_PIN_IGNORE_BIT 3
`define PMC_PRESCALE_HZ 4096
`define PMC_CLK_HZ 100000000
// Cycles per prescaler tick: 100 MHz / 4096 Hz, rounded down
`define PMC_TICK_CYCLES (`PMC_CLK_HZ / `PMC_PRESCALE_HZ)
`define PMC_CLK_PER_MS 100000
`define PMC_TICK_W 15
`define PMC_CNT_W 32
`define PMC_ACK_CYCLES 16
`define PMC_ACK_W 5

`endif

// *** hw/power_mode_pkg.sv ***
// Types for the power mode controller
package power_mode_pkg;
   typedef enum logic [2:0] {
      ST_ACTIVE  = 3'h0,
      ST_STANDBY = 3'h1,
      ST_LISTEN_WAIT = 3'h3,
      ST_LISTEN_RX = 3'h2,
      ST_SLEEP   = 3'h6
   } power_state_t;

   typedef enum logic [1:0] {
      SEL_ACTIVE  = 2'h0,
      SEL_STANDBY = 2'h1,
      SEL_LISTEN  = 2'h2,
      SEL_SLEEP   = 2'h3
   } mode_sel_t;
endpackage : power_mode_pkg

// *** hw/pin_sync.sv ***
// Two-stage synchroniser for one level input
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Level in and out
   input wire logic async_in,
   output logic sync_out
);
   logic meta_reg;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : pin_sync
`default_nettype wire

// *** hw/power_mode_control.sv ***
// Power state controller: mode pins, listen timer, serial/receiver gating
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_regs.svh"
module power_mode_control
   import power_mode_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Host mode pins
   input wire logic sleep_req_in,
   input wire logic radio_off_input_in,
   // Configuration
   input wire logic [15:0] config_flag_word_in,
   input wire logic [15:0] listen_prescaler_in,
   input wire logic [15:0] listen_countdown_in,
   input wire logic [15:0] listen_receive_window_ms_in,
   // Pending transfer from the serial path
   input wire logic xfer_busy_in,
   // Gating and status
   output logic uart_en_out,
   output logic radio_tx_en_out,
   output logic radio_rx_en_out,
   output logic flow_ctrl_out,
   output logic [2:0] state_out
);
   // ----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ----------------------------------------------------------------
   logic sleep_s;
   logic roff_s;
   logic sleep_d_reg;
   logic roff_d_reg;

   pin_sync u_sync_sleep (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(sleep_req_in),
      .sync_out(sleep_s)
   );

   pin_sync u_sync_roff (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(radio_off_input_in),
      .sync_out(roff_s)
   );

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sleep_d_reg <= 1'b0;
         roff_d_reg <= 1'b0;
      end else begin
         sleep_d_reg <= sleep_s;
         roff_d_reg <= roff_s;
      end
   end

   wire pins_ignored = config_flag_word_in[`PMC_CFG_PIN_IGNORE_BIT];
   wire fall_seen = (sleep_d_reg & ~sleep_s) | (roff_d_reg & ~roff_s);
   // Ignored pins fall back to active, as if both were held low
   wire [1:0] raw_sel = {sleep_s, roff_s};
   wire mode_sel_t sel = pins_ignored ? SEL_ACTIVE : mode_sel_t'(raw_sel);

   // ----------------------------------------------------------------
   // Listen timer: prescaler ticks and millisecond window
   // ----------------------------------------------------------------
   logic [`PMC_TICK_W-1:0] tick_cnt_reg;
   logic tick;
   logic [`PMC_CNT_W-1:0] pre_cnt_reg;
   logic [`PMC_CNT_W-1:0] pre_goal;
   logic [`PMC_CNT_W-1:0] win_cnt_reg;
   logic [`PMC_CNT_W-1:0] win_goal;
   logic pre_done;
   logic win_done;

   assign tick = (tick_cnt_reg == `PMC_TICK_W'(`PMC_TICK_CYCLES - 1));
   // Countdown times prescaler, at least one tick so a zero never stalls
   wire [`PMC_CNT_W-1:0] pre_prod = 32'(listen_prescaler_in) *
                                    32'(listen_countdown_in);
   assign pre_goal = (pre_prod == 32'h0) ? 32'h1 : pre_prod;
   assign win_goal = (listen_receive_window_ms_in == 16'h0) ? 32'h1 :
                     32'(listen_receive_window_ms_in) * `PMC_CLK_PER_MS;
   assign pre_done = (pre_cnt_reg >= pre_goal - 32'h1) && tick;
   assign win_done = (win_cnt_reg >= win_goal - 32'h1);

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   power_state_t state_reg;
   power_state_t state_next;
   logic in_listen;
   logic sleep_bound;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_ACTIVE: begin
            // Pending transfers finish first
            if (sel != SEL_ACTIVE && !flow_ctrl_out && !xfer_busy_in) begin
               unique case (sel)
                  SEL_STANDBY: state_next = ST_STANDBY;
                  SEL_LISTEN: state_next = ST_LISTEN_WAIT;
                  SEL_SLEEP: state_next = ST_SLEEP;
                  default: state_next = ST_ACTIVE;
               endcase
            end
         end
         ST_STANDBY: begin
            if (sel == SEL_ACTIVE) state_next = ST_ACTIVE;
            else if (sel == SEL_LISTEN) state_next = ST_LISTEN_WAIT;
            else if (sel == SEL_SLEEP) state_next = ST_SLEEP;
         end
         ST_LISTEN_WAIT: begin
            if (sel != SEL_LISTEN) state_next = ST_ACTIVE;
            else if (pre_done) state_next = ST_LISTEN_RX;
         end
         ST_LISTEN_RX: begin
            if (sel != SEL_LISTEN) state_next = ST_ACTIVE;
            else if (win_done) state_next = ST_LISTEN_WAIT;
         end
         ST_SLEEP: begin
            // A falling pin edge or the pin-ignore bit wakes; pins held high keep it asleep
            if (fall_seen || pins_ignored) state_next = ST_ACTIVE;
         end
         default: state_next = ST_ACTIVE;
      endcase
   end

   assign in_listen = (state_reg == ST_LISTEN_WAIT) ||
                      (state_reg == ST_LISTEN_RX);
   assign sleep_bound = (state_next == ST_SLEEP) != (state_reg == ST_SLEEP);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) state_reg <= ST_ACTIVE;
      else state_reg <= state_next;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tick_cnt_reg <= '0;
         pre_cnt_reg <= '0;
         win_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= (tick || !in_listen) ? '0 : tick_cnt_reg + 1'b1;
         if (state_reg != ST_LISTEN_WAIT || pre_done) pre_cnt_reg <= '0;
         else if (tick) pre_cnt_reg <= pre_cnt_reg + 32'h1;
         if (state_reg != ST_LISTEN_RX || win_done) win_cnt_reg <= '0;
         else win_cnt_reg <= win_cnt_reg + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Flow-control acknowledge and gating outputs
   // ----------------------------------------------------------------
   // Flow control is high (busy) while a transfer runs, while asleep,
   // and for a short pulse around every sleep boundary
   logic [`PMC_ACK_W-1:0] ack_cnt_reg;
   wire ack_busy = (ack_cnt_reg != '0);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ack_cnt_reg <= '0;
      end else if (sleep_bound) begin
         ack_cnt_reg <= `PMC_ACK_W'(`PMC_ACK_CYCLES);
      end else if (ack_busy) begin
         ack_cnt_reg <= ack_cnt_reg - 1'b1;
      end
   end

   wire uart_on = (state_next != ST_SLEEP);
   wire rx_on = (state_next == ST_ACTIVE) || (state_next == ST_LISTEN_RX);
   wire tx_on = (state_next == ST_ACTIVE) || (state_next == ST_STANDBY);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         uart_en_out <= 1'b1;
         radio_tx_en_out <= 1'b1;
         radio_rx_en_out <= 1'b1;
         flow_ctrl_out <= 1'b0;
         state_out <= ST_ACTIVE;
      end else begin
         uart_en_out <= uart_on;
         radio_tx_en_out <= tx_on;
         radio_rx_en_out <= rx_on;
         flow_ctrl_out <= xfer_busy_in || !uart_on || ack_busy ||
                          sleep_bound;
         state_out <= state_next;
      end
   end
endmodule : power_mode_control
`default_nettype wire

// *** sim/host_model.sv ***
// Host model driving the two mode pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock, reset and requested mode
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [1:0] sel_in,
   // Mode pins
   output logic sleep_req_out,
   output logic radio_off_out
);
   // Pins never float: low out of reset, always driven after
   always_ff @(negedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         {sleep_req_out, radio_off_out} <= 2'h0;
      else
         {sleep_req_out, radio_off_out} <= sel_in;
   end
endmodule : host_model
`default_nettype wire

// *** sim/power_mode_sva.sv ***
// Assertion checker for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module power_mode_sva
   import power_mode_pkg::*;
(
   // Watched ports
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic sleep_req_in,
   input wire logic radio_off_input_in,
   input wire logic [15:0] config_flag_word_in,
   input wire logic xfer_busy_in,
   input wire logic uart_en_out,
   input wire logic radio_tx_en_out,
   input wire logic radio_rx_en_out,
   input wire logic flow_ctrl_out,
   input wire logic [2:0] state_out
);
   // ----------------
   // Properties
   // ----------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic pins_hi = sleep_req_in && radio_off_input_in;
   wire logic en_all = uart_en_out && radio_tx_en_out && radio_rx_en_out;
   property p_act; state_out == ST_ACTIVE |-> en_all; endproperty
   a_act: assert property (p_act) else $error("active gating");
   property p_stby; state_out == ST_STANDBY |->
      !radio_rx_en_out && uart_en_out && radio_tx_en_out; endproperty
   a_stby: assert property (p_stby) else $error("standby");
   property p_sleep; state_out == ST_SLEEP |-> flow_ctrl_out &&
      !uart_en_out && !radio_tx_en_out && !radio_rx_en_out; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep");
   property p_lrx; state_out == ST_LISTEN_RX |-> radio_rx_en_out; endproperty
   a_lrx: assert property (p_lrx) else $error("listen rx");
   property p_leave; $past(state_out) == ST_ACTIVE && state_out != ST_ACTIVE
      |-> !$past(flow_ctrl_out) && !$past(xfer_busy_in); endproperty
   a_leave: assert property (p_leave) else $error("left early");
   property p_ack; $past(state_out) == ST_SLEEP && state_out != ST_SLEEP
      |-> flow_ctrl_out [*8]; endproperty
   a_ack: assert property (p_ack) else $error("wake ack");
   property p_hold; pins_hi [*4] ##0 state_out == ST_SLEEP &&
      !config_flag_word_in[3] |=> state_out == ST_SLEEP; endproperty
   a_hold: assert property (p_hold) else $error("woke early");
   property p_ign; config_flag_word_in[3] [*4] |=> state_out == ST_ACTIVE;
   endproperty
   a_ign: assert property (p_ign) else $error("pins used");
   property p_sync; $rose(sleep_req_in) |=> $stable(state_out); endproperty
   a_sync: assert property (p_sync) else $error("unsynced");
   c_sleep: cover property (state_out == ST_SLEEP);
   c_lrx: cover property (state_out == ST_LISTEN_RX);
   c_busy: cover property (xfer_busy_in && state_out == ST_ACTIVE);
endmodule : power_mode_sva
bind power_mode_control power_mode_sva chk (.clk_in, .rst_b_in,
   .sleep_req_in, .radio_off_input_in, .config_flag_word_in, .xfer_busy_in,
   .uart_en_out, .radio_tx_en_out, .radio_rx_en_out, .flow_ctrl_out,
   .state_out);
`default_nettype wire

// *** sim/power_mode_control_bench.sv ***
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module power_mode_control_bench;
   import power_mode_pkg::*;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [15:0] cfg = 16'h0000;
   logic busy = 1'b0;
   wire logic slp, roff, uart, tx, rx, flow;
   wire logic [2:0] st;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #5 clk_in = ~clk_in;
   host_model host (.clk_in, .rst_b_in, .sel_in(sel), .sleep_req_out(slp),
      .radio_off_out(roff));
   // Short listen timing: one tick wait, 1 ms window
   power_mode_control DUT (.clk_in, .rst_b_in, .sleep_req_in(slp),
      .radio_off_input_in(roff), .config_flag_word_in(cfg),
      .listen_prescaler_in(16'h0001), .listen_countdown_in(16'h0001),
      .listen_receive_window_ms_in(16'h0001), .xfer_busy_in(busy),
      .uart_en_out(uart), .radio_tx_en_out(tx), .radio_rx_en_out(rx),
      .flow_ctrl_out(flow), .state_out(st));
   // ----------------
   // Checking helpers
   // ----------------
   function automatic logic [2:0] st_of(logic [1:0] s);
      return s == 2'h0 ? ST_ACTIVE : s == 2'h1 ? ST_STANDBY :
         s == 2'h2 ? ST_LISTEN_WAIT : ST_SLEEP;
   endfunction : st_of
   task automatic check(logic [2:0] seen, logic [2:0] want);
      n_tests++;
      if (seen !== want) begin
         errors++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic summarize();
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // Wake and mode changes may pass through active: wait bounded
   task automatic go(logic [1:0] s);
      int k;
      @(negedge clk_in) sel <= s;
      for (k = 0; k < 200 && st !== st_of(s); k++) @(negedge clk_in);
      check(st, st_of(s));
      if (s == 2'h2)
         check({uart, tx, rx}, 3'h4);
      else
         check({uart, tx, rx}, s == 2'h0 ? 3'h7 : s == 2'h1 ? 3'h6 : 3'h0);
   endtask : go
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         summarize();
      end
   end
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      int i;
      void'($urandom(60));
      repeat (3) @(posedge clk_in);
      check({uart, tx, rx}, 3'h7);
      check({st[1:0], flow}, 3'h0);
      @(negedge clk_in) rst_b_in <= 1'b1;
      for (i = 0; i < 4; i++) go(2'(i));
      repeat (14) go(2'($urandom_range(0, 3)));
      go(2'h0);
      @(negedge clk_in) busy <= 1'b1;
      sel <= 2'h1;
      repeat (20) @(negedge clk_in);
      check(st, ST_ACTIVE);
      check({2'h0, flow}, 3'h1);
      busy <= 1'b0;
      go(2'h1);
      go(2'h3);
      @(negedge clk_in) cfg <= 16'h0008;
      repeat (10) @(negedge clk_in);
      check(st, ST_ACTIVE);
      cfg <= 16'($urandom) & 16'hfff7;
      go(2'h2);
      for (i = 0; i < 30000 && rx !== 1'b1; i++) @(negedge clk_in);
      check({2'h0, i > 24405 && i < 24420}, 3'h1);
      check(st, ST_LISTEN_RX);
      go(2'h0);
      summarize();
   end
endmodule : power_mode_control_bench
`default_nettype wire
